// ===== rtl/sramwc_host.sv
`timescale 1ns/1ps
// How it works
// RL1: The write begins when the later of select and strobe falls.
// RL2: With gate low, memory drives data after select-to-output-on delay.
// RL3: Memory stops driving within write-to-output-off delay after strobe falls.
// RL4: Host drives write data only after write-to-output-off delay elapses.
// RL5: Host may keep output gate high through writes, avoiding contention.
// RL6: Strobe-ended write: data setup and hold referenced to strobe rise.
// RL7: Strobe rising with select low and gate low re-enables memory outputs.
// RL8: Re-enabled outputs show the word just written unless inputs change.
// RL9: Select-ended write: data setup and hold referenced to select rise.
// RL10: Select-ended write leaves memory data pins undriven.
// RL11: Fast write: gate high, select low, strobe per write, outputs off.
// RL12: Host may issue back-to-back fast writes without turnaround time.
// RL13: With select low, fourteen address lines pick one of 16384 words.
// RL14: With select high, memory is deselected and outputs disabled.
// RL15: Memory drives data only while output gate is low.
// RL16: Strobe already low at select fall keeps memory outputs off.
// RL17: Host holds address stable while select and strobe are both low.
module sramwc_host
	import sramwc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// User request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rd_valid,
	output logic [DATA_W-1:0] rd_data,
	// Memory pins
	output logic [ADDR_W-1:0] word_address_lines,
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_gate_n,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe
);
	sramwc_state_t state, next_state;
	logic [ADDR_W-1:0] next_addr;
	logic next_cs_n, next_we_n, next_oe_n, next_dq_oe, next_ready, next_rd_valid;
	logic [DATA_W-1:0] next_dq_out, next_rd_data;
	logic t_load, t_done;
	logic [CYC_W-1:0] t_count;

	sramwc_timer u_timer
	(
		.clk(clk),
		.srst(srst),
		.load(t_load),
		.count(t_count),
		.done(t_done)
	);

	always_comb
	begin
		next_state = state;
		next_addr = word_address_lines;
		next_cs_n = chip_select_n;
		next_we_n = write_strobe_n;
		next_oe_n = output_gate_n;
		next_dq_oe = dq_oe;
		next_dq_out = dq_out;
		next_ready = 1'b0;
		next_rd_valid = 1'b0;
		next_rd_data = rd_data;
		t_load = 1'b0;
		t_count = '0;
		case (state)
			ST_IDLE:
			begin
				next_ready = 1'b1;
				if (req_valid && req_ready)
				begin
					next_ready = 1'b0;
					next_addr = req_addr; // RL13
					next_cs_n = 1'b0;
					if (req_write)
					begin
						// Gate stays high so memory never drives during writes
						next_oe_n = 1'b1; // RL5 RL11 RL15
						next_dq_out = req_wdata;
						next_state = ST_SETUP;
					end
					else
					begin
						next_oe_n = 1'b0;
						next_dq_oe = 1'b0;
						t_load = 1'b1;
						t_count = CYC_W'(READ_CYC);
						next_state = ST_RD;
					end
				end
				else
					next_cs_n = 1'b1; // RL14
			end
			ST_SETUP:
			begin
				// Address settled one cycle before strobe falls; write starts now
				next_we_n = 1'b0; // RL1 RL17
				t_load = 1'b1;
				t_count = CYC_W'(OFF_CYC);
				next_state = ST_STROBE;
			end
			ST_STROBE:
			begin
				// Data driven only once output-off delay has passed
				if (t_done && !dq_oe)
				begin
					next_dq_oe = 1'b1; // RL3 RL4
					t_load = 1'b1;
					t_count = CYC_W'(PULSE_CYC);
				end
				else if (t_done && dq_oe)
				begin
					// Strobe-ended write; data held past the rise
					next_we_n = 1'b1; // RL6
					t_load = 1'b1;
					t_count = CYC_W'(HOLD_CYC);
					next_state = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				// Hold is one cycle, so ready stands only at the edge that ends it
				if (!t_done)
					next_ready = 1'b1;
				else
				begin
					next_dq_oe = 1'b0;
					// Back-to-back requests keep select low
					if (req_valid && req_ready && req_write)
					begin
						next_addr = req_addr; // RL12 RL17
						next_dq_out = req_wdata;
						next_state = ST_SETUP;
					end
					else if (req_valid && req_ready)
					begin
						next_addr = req_addr; // RL13
						next_oe_n = 1'b0;
						t_load = 1'b1;
						t_count = CYC_W'(READ_CYC);
						next_state = ST_RD;
					end
					else
					begin
						next_cs_n = 1'b1; // RL14
						next_state = ST_IDLE;
					end
				end
			end
			ST_RD:
			begin
				if (t_done)
				begin
					next_rd_data = dq_in; // RL2
					next_rd_valid = 1'b1;
					next_oe_n = 1'b1;
					next_cs_n = 1'b1;
					t_load = 1'b1;
					t_count = CYC_W'(TURN_CYC);
					next_state = ST_TURN;
				end
			end
			ST_TURN:
			begin
				if (t_done)
					next_state = ST_IDLE;
			end
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= ST_IDLE;
			word_address_lines <= '0;
			chip_select_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
			dq_oe <= 1'b0;
			dq_out <= '0;
			req_ready <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= '0;
		end
		else
		begin
			state <= next_state;
			word_address_lines <= next_addr;
			chip_select_n <= next_cs_n;
			write_strobe_n <= next_we_n;
			output_gate_n <= next_oe_n;
			dq_oe <= next_dq_oe;
			dq_out <= next_dq_out;
			req_ready <= next_ready;
			rd_valid <= next_rd_valid;
			rd_data <= next_rd_data;
		end
	end
endmodule

// ===== inc/sramwc_pkg.sv
package sramwc_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 4;
	localparam int CLK_PERIOD_NS = 20;
	// Worst-case speed grade figures, in ns
	localparam int WRITE_TO_OUTPUT_OFF_DELAY_NS = 25;
	localparam int WRITE_PULSE_NS = 40;
	localparam int WRITE_CYCLE_NS = 55;
	localparam int ADDR_SETUP_END_NS = 40;
	localparam int ADDR_HOLD_NS = 5;
	localparam int READ_ACCESS_NS = 55;
	localparam int BUS_OFF_NS = 25;
	// Least times round up, at least one cycle
	function automatic int ns_to_cycles(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int OFF_CYC = ns_to_cycles(WRITE_TO_OUTPUT_OFF_DELAY_NS);
	localparam int PULSE_CYC = ns_to_cycles(WRITE_PULSE_NS);
	localparam int HOLD_CYC = ns_to_cycles(ADDR_HOLD_NS);
	localparam int READ_CYC = ns_to_cycles(READ_ACCESS_NS);
	localparam int TURN_CYC = ns_to_cycles(BUS_OFF_NS);
	localparam int CYC_W = 4;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b011,
		ST_HOLD = 3'b010,
		ST_RD = 3'b110,
		ST_TURN = 3'b111
	} sramwc_state_t;
endpackage

// ===== rtl/sramwc_timer.sv
`timescale 1ns/1ps
module sramwc_timer
	import sramwc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic load,
	input wire logic [CYC_W-1:0] count,
	output logic done
);
	logic [CYC_W-1:0] left;
	logic [CYC_W-1:0] next_left;

	always_comb
	begin
		next_left = left;
		if (load)
			next_left = count;
		else if (left != '0)
			next_left = left - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			left <= '0;
		else
			left <= next_left;
	end

	// Count state only; load is decided from done, so done must not look at load
	assign done = (left == '0);
endmodule

// ===== test/sramwc_mem.sv
`timescale 1ns/1ps
module sramwc_mem
	import sramwc_pkg::*;
(
	// Memory pins
	input wire logic [ADDR_W-1:0] a,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [DATA_W-1:0] d,
	output logic [DATA_W-1:0] q
);
	logic [DATA_W-1:0] mem [2**ADDR_W];
	logic [DATA_W-1:0] last = 4'h0;
	logic arm = 1'b0;
	// Earlier rise of select or strobe commits
	always @(cs_n or we_n)
	begin
		if (arm && (cs_n || we_n))
			mem[a] = d;
		arm = !cs_n && !we_n;
	end
	// Released pins show the inverse of the last word
	always @*
	begin
		if (!cs_n && !oe_n && we_n)
			last = mem[a];
		q = (!cs_n && !oe_n && we_n) ? last : ~last;
	end
endmodule

// ===== test/sramwc_host_props.sv
`timescale 1ns/1ps
module sramwc_host_props
	import sramwc_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic srst,
	input wire logic rd_valid,
	input wire logic [ADDR_W-1:0] word_address_lines,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_gate_n,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic dq_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	a_gate_in_write: assert property (!write_strobe_n |-> output_gate_n && !chip_select_n)
		else $error("gate or select wrong in write");
	a_no_contention: assert property (dq_oe |-> output_gate_n)
		else $error("data driven with gate low");
	a_off_delay: assert property ($fell(write_strobe_n) |-> !dq_oe[*3] ##1 dq_oe)
		else $error("data driven too early or late");
	a_pulse_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*6] ##1 write_strobe_n)
		else $error("strobe width wrong");
	a_data_setup: assert property ($rose(write_strobe_n) |-> dq_oe && $past(dq_oe) && $stable(dq_out))
		else $error("data not set up at strobe rise");
	a_addr_stable: assert property (!chip_select_n && !write_strobe_n |=> $stable(word_address_lines))
		else $error("address moved in write");
	a_select_first: assert property ($fell(write_strobe_n) |-> !$past(chip_select_n))
		else $error("strobe fell before select");
	a_read_gate: assert property (rd_valid |-> !$past(output_gate_n) && !$past(chip_select_n))
		else $error("read without gate");
endmodule
bind sramwc_host sramwc_host_props sramwc_host_props_inst (.clk, .srst, .rd_valid, .word_address_lines,
	.chip_select_n, .write_strobe_n, .output_gate_n, .dq_out, .dq_oe);

// ===== test/sramwc_host_bench.sv
`timescale 1ns/1ps
module sramwc_host_bench
	import sramwc_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [ADDR_W-1:0] req_addr = 14'h0;
	logic [DATA_W-1:0] req_wdata = 4'h0;
	logic req_ready, rd_valid, chip_select_n, write_strobe_n, output_gate_n, dq_oe;
	logic [DATA_W-1:0] rd_data, dq_out, q, dq_in;
	logic [ADDR_W-1:0] word_address_lines, addr;
	logic [DATA_W-1:0] ref_mem [int];
	logic [ADDR_W-1:0] aq [$];
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	assign dq_in = dq_oe ? dq_out : q;
	always #10 clk = ~clk;
	sramwc_host sramwc_host_inst (.clk, .srst, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
		.rd_valid, .rd_data, .word_address_lines, .chip_select_n, .write_strobe_n, .output_gate_n,
		.dq_in, .dq_out, .dq_oe);
	sramwc_mem sramwc_mem_inst (.a(word_address_lines), .cs_n(chip_select_n), .we_n(write_strobe_n),
		.oe_n(output_gate_n), .d(dq_in), .q(q));
	task automatic print_verdict;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
		check_count++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic req(input logic w, input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		@(negedge clk);
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata = w ? ref_mem[a] : DATA_W'($urandom);
		while (req_ready !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		req_valid = 1'b0;
		while (!w && rd_valid !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 40)
		begin
			failures++;
			$display("ERROR %0t request timed out", $time);
		end
		if (!w)
			chk(rd_data, ref_mem[a]);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			failures++;
			print_verdict;
		end
	end
	initial
	begin
		void'($urandom(32'h6caf));
		repeat (4) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk({chip_select_n, write_strobe_n, output_gate_n, dq_oe}, 4'he);
		for (int i = 0; i < 24; i++)
		begin
			addr = (i == 0) ? 14'h3fff : ADDR_W'($urandom);
			ref_mem[addr] = DATA_W'($urandom);
			req(1'b1, addr);
			req(1'b0, addr);
			if (i[0])
				req(1'b0, 14'h3fff);
		end
		$display("test interleaved done");
		for (int i = 0; i < 10; i++)
		begin
			addr = (i == 0) ? 14'h0 : ADDR_W'($urandom);
			ref_mem[addr] = DATA_W'($urandom);
			aq.push_back(addr);
			req(1'b1, addr);
		end
		foreach (aq[k])
			req(1'b0, aq[k]);
		$display("test burst done");
		print_verdict;
	end
endmodule
